/* File: rtl/pdm_mic_out.sv */
/*
  Holds the digital output side of a PDM microphone: a sigma-delta
  modulator fed through a two-entry buffer, slot-timed drive of the shared
  data line, stopped-clock sleep detection and the wake-up cycle count.
  Assumes the bit clock and the strap are synchronous to I_REF_CLK, and
  that the reference clock is much faster than the bit clock.
*/
module pdm_mic_out
  import pdm_mic_pkg::*;
#(
  parameter int unsigned SLEEP_CYCLES = SLEEP_REF_CYCLES,
  parameter int unsigned WAKE_CYCLES = WAKE_BIT_CYCLES,
  parameter int unsigned SAMPLE_WIDTH = SAMPLE_W
) (
  // Clock and reset.
  input wire logic I_REF_CLK,
  input wire logic I_RST,
  // Bit clock from the receiver and channel-select strap.
  input wire logic I_PDM_CLK,
  input wire logic I_LR_SEL,
  // Signed samples from the front end.
  input wire logic I_SAMPLE_VALID,
  input wire logic [SAMPLE_WIDTH-1:0] I_SAMPLE,
  output logic O_SAMPLE_READY,
  // Shared data line, split into level and enable.
  output logic O_PDM_DATA,
  output logic O_PDM_OE,
  // Power status.
  output logic O_SLEEP,
  output logic O_OUT_VALID
);

  localparam logic [SLEEP_CNT_W-1:0] SLEEP_LIMIT = SLEEP_CNT_W'(SLEEP_CYCLES - 1);
  localparam logic [WAKE_CNT_W-1:0] WAKE_LIMIT = WAKE_CNT_W'(WAKE_CYCLES);
  localparam logic signed [ACC_W-1:0] FS_POS = ACC_W'((1 << (SAMPLE_WIDTH - 1)) - 1);
  localparam logic signed [ACC_W-1:0] FS_NEG = -ACC_W'(1 << (SAMPLE_WIDTH - 1));

  ////////////////////////////////////////////////////////////////////////////
  // Declarations.
  pwr_state_t state_q;
  pwr_state_t state_d;
  logic pdm_clk_q;
  logic sel_q;
  logic [SLEEP_CNT_W-1:0] idle_cnt_q;
  logic [WAKE_CNT_W-1:0] wake_cnt_q;
  logic signed [ACC_W-1:0] acc_q;
  logic signed [SAMPLE_WIDTH-1:0] cur_sample_q;
  logic bit_q;
  logic pdm_data_q;
  logic pdm_oe_q;
  logic sleep_q;
  logic out_valid_q;
  logic buf_valid;
  logic [SAMPLE_WIDTH-1:0] buf_data;
  logic buf_ready;

  ////////////////////////////////////////////////////////////////////////////
  // Edge decode of the sampled bit clock and slot selection.
  wire clk_rise = I_PDM_CLK & ~pdm_clk_q;
  wire clk_fall = ~I_PDM_CLK & pdm_clk_q;
  wire any_edge = clk_rise | clk_fall;
  wire is_left = (sel_q == SEL_LEFT);
  // Left launches on the fall, right on the rise; each uses one edge only.
  wire launch = is_left ? clk_fall : clk_rise;
  wire release_edge = is_left ? clk_rise : clk_fall;
  wire idle_done = (idle_cnt_q == SLEEP_LIMIT);
  wire wake_done = (wake_cnt_q == WAKE_LIMIT);
  wire awake = (state_q != ST_SLEEP);

  // Modulator step: feedback of full scale, sign of the accumulator is the bit.
  wire signed [ACC_W-1:0] fb = bit_q ? FS_POS : FS_NEG;
  wire signed [ACC_W-1:0] x_ext = ACC_W'(cur_sample_q);
  wire signed [ACC_W-1:0] acc_d = acc_q + x_ext - fb;
  wire bit_d = ~acc_d[ACC_W-1];
  wire step = launch & awake;
  assign buf_ready = step;

  ////////////////////////////////////////////////////////////////////////////
  // Input buffer; a launch with no sample waiting repeats the last one.
  pdm_skid_buf #(
    .WIDTH(SAMPLE_WIDTH),
    .DEPTH(BUF_DEPTH)
  ) u_buf (
    .i_clk(I_REF_CLK),
    .i_rst(I_RST),
    .i_valid(I_SAMPLE_VALID),
    .i_data(I_SAMPLE),
    .o_ready(O_SAMPLE_READY),
    .o_valid(buf_valid),
    .o_data(buf_data),
    .i_ready(buf_ready)
  );

  ////////////////////////////////////////////////////////////////////////////
  // Bit-clock history and strap capture; the strap is taken while reset holds.
  always_ff @(posedge I_REF_CLK) begin
    pdm_clk_q <= I_PDM_CLK;
    if (I_RST) begin
      sel_q <= I_LR_SEL;
    end
  end

  ////////////////////////////////////////////////////////////////////////////
  // Stopped-clock timer: counts reference cycles since the last bit-clock edge.
  always_ff @(posedge I_REF_CLK) begin
    if (I_RST || any_edge) begin
      idle_cnt_q <= '0;
    end else if (!idle_done) begin
      idle_cnt_q <= idle_cnt_q + 1'b1;
    end
  end

  ////////////////////////////////////////////////////////////////////////////
  // Wake counter: bit-clock rising edges since the clock became active.
  always_ff @(posedge I_REF_CLK) begin
    if (I_RST || state_q == ST_SLEEP) begin
      wake_cnt_q <= '0;
    end else if (state_q == ST_WAKE && clk_rise && !wake_done) begin
      wake_cnt_q <= wake_cnt_q + 1'b1;
    end
  end

  ////////////////////////////////////////////////////////////////////////////
  // Power state selection.
  always_comb begin
    state_d = state_q;
    case (state_q)
      ST_WAKE: begin
        if (idle_done) begin
          state_d = ST_SLEEP;
        end else if (wake_done) begin
          state_d = ST_RUN;
        end
      end
      ST_RUN: begin
        if (idle_done) begin
          state_d = ST_SLEEP;
        end
      end
      ST_SLEEP: begin
        if (any_edge) begin
          state_d = ST_WAKE;
        end
      end
      default: begin
        state_d = ST_SLEEP;
      end
    endcase
  end

  // Power state register; power-up starts counting as after a wake.
  always_ff @(posedge I_REF_CLK) begin
    if (I_RST) begin
      state_q <= ST_WAKE;
    end else begin
      state_q <= state_d;
    end
  end

  ////////////////////////////////////////////////////////////////////////////
  // Sample holding register fed by the buffer at each launch.
  always_ff @(posedge I_REF_CLK) begin
    if (I_RST) begin
      cur_sample_q <= '0;
    end else if (step && buf_valid) begin
      cur_sample_q <= buf_data;
    end
  end

  // Sigma-delta modulator: the density of ones follows the sample value.
  always_ff @(posedge I_REF_CLK) begin
    if (I_RST) begin
      acc_q <= '0;
      bit_q <= 1'b0;
    end else if (step) begin
      acc_q <= acc_d;
      bit_q <= bit_d;
    end
  end

  ////////////////////////////////////////////////////////////////////////////
  // Line driver: drive on the launch edge, release on the opposite edge.
  always_ff @(posedge I_REF_CLK) begin
    if (I_RST) begin
      pdm_data_q <= 1'b0;
      pdm_oe_q <= 1'b0;
    end else if (state_d != ST_RUN) begin
      // Look at the next state so the line is released on the same edge as sleep is flagged.
      pdm_oe_q <= 1'b0;
    end else if (launch) begin
      pdm_data_q <= bit_d;
      pdm_oe_q <= 1'b1;
    end else if (release_edge) begin
      pdm_oe_q <= 1'b0;
    end
  end

  // Status flags.
  always_ff @(posedge I_REF_CLK) begin
    if (I_RST) begin
      sleep_q <= 1'b0;
      out_valid_q <= 1'b0;
    end else begin
      sleep_q <= (state_d == ST_SLEEP);
      out_valid_q <= (state_d == ST_RUN);
    end
  end

  assign O_PDM_DATA = pdm_data_q;
  assign O_PDM_OE = pdm_oe_q;
  assign O_SLEEP = sleep_q;
  assign O_OUT_VALID = out_valid_q;

endmodule

/* File: rtl/pdm_mic_pkg.sv */
/*
  Holds the shared constants of the microphone output logic: clock rate,
  sleep and wake timing, sample width and the output state encoding.
  Assumes a single 20 MHz reference clock inside the device.
*/
package pdm_mic_pkg;

  ////////////////////////////////////////////////////////////////////////////
  // Reference clock.
  localparam int unsigned REF_CLK_HZ = 20000000;
  localparam int unsigned REF_CLK_KHZ = REF_CLK_HZ / 1000;

  ////////////////////////////////////////////////////////////////////////////
  // Sleep entry: no bit-clock edge for this long means the clock has stopped.
  localparam int unsigned SLEEP_TIME_US = 1000;
  // Longest time, so the count rounds down.
  localparam int unsigned SLEEP_REF_CYCLES = (SLEEP_TIME_US * REF_CLK_KHZ) / 1000;
  localparam int unsigned SLEEP_CNT_W = 16;

  ////////////////////////////////////////////////////////////////////////////
  // Wake-up and power-up: bit-clock cycles before output becomes valid.
  localparam int unsigned WAKE_BIT_CYCLES = 32768;
  localparam int unsigned WAKE_CNT_W = 17;

  ////////////////////////////////////////////////////////////////////////////
  // Modulator input word and accumulator widths.
  localparam int unsigned SAMPLE_W = 16;
  localparam int unsigned ACC_W = 19;
  localparam int unsigned BUF_DEPTH = 2;

  ////////////////////////////////////////////////////////////////////////////
  // Channel-select strap levels.
  localparam logic SEL_RIGHT = 1'b0;
  localparam logic SEL_LEFT = 1'b1;

  ////////////////////////////////////////////////////////////////////////////
  // Power state, one-hot.
  typedef enum logic [2:0] {
    ST_WAKE  = 3'b001,
    ST_RUN   = 3'b010,
    ST_SLEEP = 3'b100
  } pwr_state_t;

endpackage

/* File: rtl/pdm_skid_buf.sv */
/*
  Holds a two-entry buffer with valid and ready on both sides.
  Assumes one clock and a synchronous active-high reset; the ready it
  gives the source is a registered not-full flag.
*/
module pdm_skid_buf #(
  parameter int unsigned WIDTH = 16,
  parameter int unsigned DEPTH = 2
) (
  // Clock and reset.
  input wire logic i_clk,
  input wire logic i_rst,
  // Filling side.
  input wire logic i_valid,
  input wire logic [WIDTH-1:0] i_data,
  output logic o_ready,
  // Draining side.
  output logic o_valid,
  output logic [WIDTH-1:0] o_data,
  input wire logic i_ready
);

  localparam int unsigned PTR_W = (DEPTH > 1) ? $clog2(DEPTH) : 1;
  localparam int unsigned CNT_W = $clog2(DEPTH + 1);

  logic [WIDTH-1:0] mem_q [DEPTH];
  logic [PTR_W-1:0] wr_ptr_q;
  logic [PTR_W-1:0] rd_ptr_q;
  logic [CNT_W-1:0] cnt_q;
  logic [CNT_W-1:0] cnt_d;
  logic ready_q;
  wire push = i_valid & ready_q;
  wire pop = i_ready & (cnt_q != '0);

  ////////////////////////////////////////////////////////////////////////////
  // Occupancy and the outward flags derived from it.
  assign cnt_d = cnt_q + CNT_W'(push) - CNT_W'(pop);
  assign o_ready = ready_q;
  assign o_valid = (cnt_q != '0);
  assign o_data = mem_q[rd_ptr_q];

  // Pointer and count update; ready is registered so the source sees a flop.
  always_ff @(posedge i_clk) begin
    if (i_rst) begin
      wr_ptr_q <= '0;
      rd_ptr_q <= '0;
      cnt_q <= '0;
      ready_q <= 1'b1;
    end else begin
      if (push) begin
        wr_ptr_q <= (wr_ptr_q == PTR_W'(DEPTH - 1)) ? '0 : wr_ptr_q + 1'b1;
      end
      if (pop) begin
        rd_ptr_q <= (rd_ptr_q == PTR_W'(DEPTH - 1)) ? '0 : rd_ptr_q + 1'b1;
      end
      cnt_q <= cnt_d;
      ready_q <= (cnt_d != CNT_W'(DEPTH));
    end
  end

  // Storage write.
  always_ff @(posedge i_clk) begin
    if (push) begin
      mem_q[wr_ptr_q] <= i_data;
    end
  end

endmodule

/* File: tb/pdm_mic_out_sva.sv */
/* Port checker for pdm_mic_out.
   Assumes the bit clock is far slower than the reference clock. */
module pdm_mic_out_sva #(
  parameter int unsigned SLEEP_CYCLES = 50,
  parameter int unsigned WAKE_CYCLES = 8
) (
  // Inputs and outputs of the watched block.
  input wire logic I_REF_CLK,
  input wire logic I_RST,
  input wire logic I_PDM_CLK,
  input wire logic I_LR_SEL,
  input wire logic O_PDM_DATA,
  input wire logic O_PDM_OE,
  input wire logic O_SLEEP,
  input wire logic O_OUT_VALID
);
  logic pclk_q, left_q;
  int unsigned idle_q, rise_q;
  wire logic edge_w = I_PDM_CLK != pclk_q;
  ////////////////////////////////////////////////////////////////////////////
  // Tracks the strap, the time since a bit-clock edge and rises since sleep.
  always_ff @(posedge I_REF_CLK) begin
    pclk_q <= I_PDM_CLK;
    if (I_RST) left_q <= I_LR_SEL;
    idle_q <= (I_RST || edge_w) ? 0 : idle_q + 1;
    rise_q <= (I_RST || O_SLEEP) ? 0 : rise_q + 32'(edge_w && I_PDM_CLK);
  end
  default clocking @(posedge I_REF_CLK); endclocking
  default disable iff (I_RST);
  ////////////////////////////////////////////////////////////////////////////
  // Line timing, sleep entry and wake count.
  a_drive_in_run: assert property ($rose(O_PDM_OE) |-> O_OUT_VALID)
    else $error("line driven outside run");
  a_sleep_quiet: assert property (O_SLEEP |-> !O_PDM_OE && !O_OUT_VALID)
    else $error("line driven in sleep");
  a_launch_slot: assert property (O_OUT_VALID && edge_w && I_PDM_CLK != left_q |-> ##[1:2] O_PDM_OE)
    else $error("no launch on slot edge");
  a_release_half: assert property (edge_w && I_PDM_CLK == left_q |-> ##[1:2] !O_PDM_OE)
    else $error("line not released");
  a_one_edge: assert property ($rose(O_PDM_OE) |-> I_PDM_CLK != left_q)
    else $error("launch on wrong edge");
  a_bit_held: assert property (O_PDM_OE && $past(O_PDM_OE) |-> $stable(O_PDM_DATA))
    else $error("bit changed while driven");
  a_sleep_early: assert property ($rose(O_SLEEP) |-> idle_q >= SLEEP_CYCLES - 1)
    else $error("sleep too early");
  a_sleep_late: assert property (idle_q == SLEEP_CYCLES + 3 |-> O_SLEEP)
    else $error("sleep too late");
  a_wake_count: assert property ($rose(O_OUT_VALID) |-> rise_q >= WAKE_CYCLES && rise_q <= WAKE_CYCLES + 1)
    else $error("wake count wrong");
  a_wake_late: assert property (rise_q == WAKE_CYCLES + 2 |-> O_OUT_VALID)
    else $error("output never valid");
endmodule
bind pdm_mic_out pdm_mic_out_sva #(.SLEEP_CYCLES(SLEEP_CYCLES), .WAKE_CYCLES(WAKE_CYCLES)) checker_i (.*);

/* File: tb/pdm_codec_model.sv */
/* Receiver model: makes the bit clock and samples the shared line.
   Assumes it runs on the microphone's reference clock. */
module pdm_codec_model #(
  parameter int HALF = 5
) (
  // Reference clock, run control and slot choice.
  input wire logic i_clk,
  input wire logic i_run,
  input wire logic i_left,
  // Shared line.
  input wire logic i_data,
  input wire logic i_oe,
  // Bit clock and captured bits.
  output logic o_pclk,
  output logic o_got,
  output logic o_bit,
  output logic o_miss
);
  int cnt = 0;
  initial o_pclk = 1'b0;
  initial o_got = 1'b0;
  // The clock stands still while stopped; a bit is taken at the end of its slot.
  always @(posedge i_clk) begin
    o_got <= 1'b0;
    if (i_run) begin
      cnt <= (cnt == HALF - 1) ? 0 : cnt + 1;
      if (cnt == HALF - 1) begin
        o_pclk <= !o_pclk;
        if (o_pclk != i_left) begin
          o_got <= 1'b1;
          o_bit <= i_data;
          o_miss <= !i_oe;
        end
      end
    end
  end
endmodule

/* File: tb/pdm_mic_out_tb.sv */
/* Self-checking bench for pdm_mic_out with the receiver model.
   Assumes short sleep and wake counts set by parameter. */
module pdm_mic_out_tb;
  timeunit 1ns;
  timeprecision 1ns;
  localparam int SC = 50;
  localparam int WC = 8;
  logic clk = 0, rst = 1, lr = 0, run = 0, sv = 0;
  logic [15:0] smp = 16'h0000;
  wire logic rdy, dat, oe, slp, ov, pclk, got, bitv, miss;
  int bad_count = 0, compares = 0;
  pdm_mic_out #(.SLEEP_CYCLES(SC), .WAKE_CYCLES(WC)) dut (.I_REF_CLK(clk), .I_RST(rst), .I_PDM_CLK(pclk),
    .I_LR_SEL(lr), .I_SAMPLE_VALID(sv), .I_SAMPLE(smp), .O_SAMPLE_READY(rdy), .O_PDM_DATA(dat),
    .O_PDM_OE(oe), .O_SLEEP(slp), .O_OUT_VALID(ov));
  pdm_codec_model #(.HALF(5)) codec (.i_clk(clk), .i_run(run), .i_left(lr), .i_data(dat), .i_oe(oe),
    .o_pclk(pclk), .o_got(got), .o_bit(bitv), .o_miss(miss));
  ////////////////////////////////////////////////////////////////////////////
  // Clock, watchdog and random offers that are held until taken.
  initial forever #25 clk = !clk;
  initial begin
    repeat (40000) @(posedge clk);
    bad_count++;
    print_verdict();
  end
  always @(posedge clk) if (!sv || rdy) sv <= ($urandom % 4) != 0;
  ////////////////////////////////////////////////////////////////////////////
  // Checking helpers.
  task automatic chk(input string nm, input logic e, input logic s);
    compares++;
    if (s !== e) begin
      bad_count++;
      $display("unexpected %s: expected %b, seen %b", nm, e, s);
    end
  endtask
  function automatic int exp_ones(input logic [15:0] v);
    return (int'($signed(v)) + 32768) * 64 / 65536;
  endfunction
  // Counts bit-clock rises until the output turns valid.
  task automatic wake();
    int n = 0;
    while (ov !== 1'b1 && n < 40) begin
      @(posedge pclk);
      n++;
      repeat (3) @(posedge clk);
    end
    chk("wake rises", 1'b1, n >= WC && n <= WC + 1);
    $display("wake done after %0d rises", n);
  endtask
  // Offers one level and measures the density of 64 captured bits.
  task automatic dens(input logic [15:0] v);
    int ones = 0, same = 0, e;
    logic prev = 1'b0;
    @(posedge clk iff (sv && rdy));
    smp <= v;
    repeat (10) @(posedge clk iff got);
    for (int n = 0; n < 64; n++) begin
      @(posedge clk iff got);
      chk("line driven", 1'b0, miss);
      ones += int'(bitv);
      same += int'(n > 0 && bitv === prev);
      prev = bitv;
    end
    e = exp_ones(v);
    chk("ones density", 1'b1, ones >= e - 4 && ones <= e + 4);
    if (v == 16'h0000) chk("alternation", 1'b1, same == 0);
    $display("level %h gave %0d ones", v, ones);
  endtask
  task automatic print_verdict();
    $display("compares %0d, mismatches %0d", compares, bad_count);
    if (bad_count == 0 && compares > 0) $display("TB: PASS");
    else $display("TB: FAIL");
    $finish;
  endtask
  ////////////////////////////////////////////////////////////////////////////
  // Both slots: start-up, fixed and random levels, sleep and wake.
  initial begin
    void'($urandom(21));
    for (int i = 0; i < 2; i++) begin
      rst <= 1'b1;
      run <= 1'b0;
      lr <= i ? pdm_mic_pkg::SEL_LEFT : pdm_mic_pkg::SEL_RIGHT;
      repeat (2) @(posedge clk);
      rst <= 1'b0;
      run <= 1'b1;
      wake();
      dens(16'h0000);
      dens(16'h7fff);
      dens(16'h8000);
      dens(16'($urandom));
      run <= 1'b0;
      repeat (SC + 8) @(posedge clk);
      chk("sleep", 1'b1, slp);
      chk("drive in sleep", 1'b0, oe);
      run <= 1'b1;
      wake();
      dens(16'($urandom));
      $display("slot test %0d done", i);
    end
    print_verdict();
  end
endmodule
